// File: pkg/xor_test_zero_skip_pkg.sv
// Package: opcodes, field positions, reset values and buses for the xor/skip decoder
package xor_test_zero_skip_pkg;
   // ---------------------------------------------------------------
   // Opcode patterns
   // ---------------------------------------------------------------
   localparam logic [6:0] OP_TEST_ZERO_SKIP = 7'h33;   // 0110 011a
   localparam logic [7:0] OP_XOR_LITERAL_ACC = 8'h0A;  // 0000 1010
   localparam logic [5:0] OP_XOR_ACC_REGISTER = 6'h06; // 0001 10da
   localparam logic [6:0] OP_PTR_ARITH = 7'h74;        // 1110 100s
   localparam logic [4:0] OP_TWO_WORD_A = 5'h1E;       // 1111 0 / 1100 / 1110 1011 etc.
   localparam logic [3:0] OP_SECOND_WORD = 4'hF;
   localparam logic [3:0] OP_MOVE_FF = 4'hC;
   localparam logic [7:0] OP_MOVE_INDEXED = 8'hEB;
   localparam logic [6:0] OP_LONG_BRANCH = 7'h76;      // 1110 110x call, 1110 1111 goto
   localparam logic [7:0] OP_GOTO = 8'hEF;
   localparam logic [7:0] OP_LOAD_PTR = 8'hEE;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_BANK_SEL = 8;
   localparam int BIT_DEST = 9;
   localparam int BIT_PTR_SUB = 8;
   localparam int BIT_REG_IMM_LSB = 0;
   localparam int BIT_PTR_SEL_LSB = 6;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [1:0] PTR_THIRD = 2'h3;
   localparam logic [1:0] PTR_STACK = 2'h2;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [1:0] SKIP_NONE = 2'h0;
   localparam logic [1:0] SKIP_ONE = 2'h1;
   localparam logic [1:0] SKIP_TWO = 2'h2;

   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } ram_wr_s;

   typedef struct packed {
      logic neg;
      logic zero;
   } flags_s;
endpackage

// File: rtl/xor_test_zero_skip_ext_set_decode.sv
// Decoder and executor for zero-test skip, xor ops and pointer literal ops
`timescale 1ns/1ps
module xor_test_zero_skip_ext_set_decode (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic extension_cfg_bit,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [7:0] bank_pointer_reg,
   input wire logic [7:0] ram_rdata,
   input wire logic [20:0] stack_top,
   output logic [11:0] ram_raddr,
   output xor_test_zero_skip_pkg::ram_wr_s ram_wr_q,
   output logic [7:0] acc_q,
   output xor_test_zero_skip_pkg::flags_s flags_q,
   output logic flags_we_q,
   output logic [11:0] indirect_pointer_0_q,
   output logic [11:0] indirect_pointer_1_q,
   output logic [11:0] indirect_pointer_2_q,
   output logic return_q,
   output logic [20:0] pc_load_q,
   output logic nop_cycle_q,
   output logic illegal_q
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {EXEC, FLUSH, FLUSH_LAST} seq_e;
   seq_e state_q;
   logic ext_on;
   logic is_tstz, is_xorl, is_xorf, is_ptr, is_two_word;
   logic [11:0] ptr [3];
   logic [11:0] ptr_d [3];
   logic [7:0] fa;
   logic [7:0] xor_res;
   logic [1:0] sel;
   logic [5:0] lit6;
   logic live;

   // Configuration bit high (unprogrammed) enables the extension
   assign ext_on = extension_cfg_bit;
   assign live = instr_valid && (state_q == EXEC);
   assign fa = instr_word[7:0];
   assign is_tstz = instr_word[15:9] == xor_test_zero_skip_pkg::OP_TEST_ZERO_SKIP;
   assign is_xorl = instr_word[15:8] == xor_test_zero_skip_pkg::OP_XOR_LITERAL_ACC;
   assign is_xorf = instr_word[15:10] == xor_test_zero_skip_pkg::OP_XOR_ACC_REGISTER;
   assign is_ptr = ext_on && (instr_word[15:9] == xor_test_zero_skip_pkg::OP_PTR_ARITH);
   assign sel = instr_word[xor_test_zero_skip_pkg::BIT_PTR_SEL_LSB +: 2];
   assign lit6 = instr_word[5:0];
   assign ptr[0] = indirect_pointer_0_q;
   assign ptr[1] = indirect_pointer_1_q;
   assign ptr[2] = indirect_pointer_2_q;

   // Word following a skip: is it the first of a two-word instruction
   assign is_two_word = (instr_word[15:12] == xor_test_zero_skip_pkg::OP_MOVE_FF)
      || (instr_word[15:9] == xor_test_zero_skip_pkg::OP_LONG_BRANCH)
      || (instr_word[15:8] == xor_test_zero_skip_pkg::OP_GOTO)
      || (instr_word[15:8] == xor_test_zero_skip_pkg::OP_LOAD_PTR)
      || (ext_on && instr_word[15:8] == xor_test_zero_skip_pkg::OP_MOVE_INDEXED);

   // ---------------------------------------------------------------
   // Operand addressing
   // ---------------------------------------------------------------
   always_comb begin
      if (instr_word[xor_test_zero_skip_pkg::BIT_BANK_SEL]) begin
         ram_raddr = {bank_pointer_reg[3:0], fa};
      end else if (ext_on && fa <= xor_test_zero_skip_pkg::INDEXED_LIMIT) begin
         ram_raddr = indirect_pointer_2_q + {4'h0, fa};
      end else begin
         ram_raddr = {{4{fa[7]}}, fa};
      end
   end

   assign xor_res = acc_q ^ (is_xorl ? fa : ram_rdata);

   // Pointer next values; only the selected one moves, with select 3 moving pointer 2
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ptr_d[i] = ptr[i];
      end
      if (live && is_ptr && sel != xor_test_zero_skip_pkg::PTR_THIRD) begin
         if (instr_word[xor_test_zero_skip_pkg::BIT_PTR_SUB]) begin
            ptr_d[sel] = ptr[sel] - {6'h00, lit6};
         end else begin
            ptr_d[sel] = ptr[sel] + {6'h00, lit6};
         end
      end else if (live && is_ptr) begin
         if (instr_word[xor_test_zero_skip_pkg::BIT_PTR_SUB]) begin
            ptr_d[xor_test_zero_skip_pkg::PTR_STACK] = ptr[2] - {6'h00, lit6};
         end else begin
            ptr_d[xor_test_zero_skip_pkg::PTR_STACK] = ptr[2] + {6'h00, lit6};
         end
      end
   end

   // ---------------------------------------------------------------
   // Skip sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= EXEC;
      end else begin
         case (state_q)
            EXEC: begin
               if (live && is_tstz && ram_rdata == 8'h00) begin
                  state_q <= FLUSH;
               end
            end
            FLUSH: begin
               // Discarded word decides whether a second flush follows
               if (instr_valid && is_two_word) begin
                  state_q <= FLUSH_LAST;
               end else if (instr_valid) begin
                  state_q <= EXEC;
               end
            end
            FLUSH_LAST: begin
               if (instr_valid) begin
                  state_q <= EXEC;
               end
            end
            default: state_q <= EXEC;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nop_cycle_q <= 1'b0;
      end else begin
         nop_cycle_q <= instr_valid && (state_q != EXEC);
      end
   end

   // ---------------------------------------------------------------
   // Accumulator, flags, write-back
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         acc_q <= xor_test_zero_skip_pkg::ACC_RESET;
         flags_q <= '0;
         flags_we_q <= 1'b0;
         ram_wr_q <= '0;
      end else begin
         flags_we_q <= 1'b0;
         ram_wr_q.we <= 1'b0;
         if (live && (is_xorl || is_xorf)) begin
            flags_q.neg <= xor_res[7];
            flags_q.zero <= xor_res == 8'h00;
            flags_we_q <= 1'b1;
            if (is_xorl || !instr_word[xor_test_zero_skip_pkg::BIT_DEST]) begin
               acc_q <= xor_res;
            end else begin
               ram_wr_q.we <= 1'b1;
               ram_wr_q.addr <= ram_raddr;
               ram_wr_q.data <= xor_res;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Pointer registers and return
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         indirect_pointer_0_q <= xor_test_zero_skip_pkg::PTR_RESET;
         indirect_pointer_1_q <= xor_test_zero_skip_pkg::PTR_RESET;
         indirect_pointer_2_q <= xor_test_zero_skip_pkg::PTR_RESET;
      end else begin
         indirect_pointer_0_q <= ptr_d[0];
         indirect_pointer_1_q <= ptr_d[1];
         indirect_pointer_2_q <= ptr_d[2];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         return_q <= 1'b0;
         pc_load_q <= '0;
         illegal_q <= 1'b0;
      end else begin
         return_q <= live && is_ptr && sel == xor_test_zero_skip_pkg::PTR_THIRD;
         if (live && is_ptr && sel == xor_test_zero_skip_pkg::PTR_THIRD) begin
            pc_load_q <= stack_top;
         end
         // Pointer arithmetic opcodes with the extension off are flagged, not run; the indexed move opener is not flagged
         illegal_q <= live && !ext_on
            && (instr_word[15:9] == xor_test_zero_skip_pkg::OP_PTR_ARITH);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_skip_one_nop: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_tstz && ram_rdata == 8'h00 ##1 instr_valid |=> nop_cycle_q)
      else $error("zero-test skip gave no no-op cycle");
   a_no_skip_nonzero: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_tstz && ram_rdata != 8'h00 |=> state_q == EXEC)
      else $error("skip taken on nonzero operand");
   a_two_word_flush: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == FLUSH && instr_valid && is_two_word |=> state_q == FLUSH_LAST)
      else $error("two-word skip lacks second no-op");
   a_bank_select: assert property (@(posedge clk) disable iff (!rst_b)
      instr_word[8] |-> ram_raddr == {bank_pointer_reg[3:0], instr_word[7:0]})
      else $error("bank pointer not used for banked access");
   a_indexed_addr: assert property (@(posedge clk) disable iff (!rst_b)
      extension_cfg_bit && !instr_word[8] && instr_word[7:0] <= 8'h5F
      |-> ram_raddr == indirect_pointer_2_q + {4'h0, instr_word[7:0]})
      else $error("indexed offset addressing wrong");
   a_xor_literal: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_xorl |=> acc_q == ($past(acc_q) ^ $past(instr_word[7:0])))
      else $error("literal xor result wrong");
   a_xor_dest_reg: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_xorf && instr_word[9] |=> ram_wr_q.we && $stable(acc_q))
      else $error("register xor did not write back");
   a_skip_flags: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_tstz |=> !flags_we_q)
      else $error("zero-test touched flags");
   a_ptr_add: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_ptr && instr_word[7:6] == 2'h0 && !instr_word[8]
      |=> indirect_pointer_0_q == $past(indirect_pointer_0_q) + {6'h00, $past(instr_word[5:0])})
      else $error("pointer add wrong");
   a_ptr_return: assert property (@(posedge clk) disable iff (!rst_b)
      live && is_ptr && instr_word[7:6] == 2'h3 |=> return_q && pc_load_q == $past(stack_top))
      else $error("add-and-return did not return");
endmodule // xor_test_zero_skip_ext_set_decode

// File: testbench/xor_test_zero_skip_ext_set_decode_bench.sv
// Self-checking bench for the xor/skip/pointer-literal decoder
`timescale 1ns/1ps
module xor_test_zero_skip_ext_set_decode_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic extension_cfg_bit = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [7:0] bank_pointer_reg = 8'h02;
   logic [7:0] ram_rdata;
   logic [20:0] stack_top = 21'h12345;
   logic [11:0] ram_raddr;
   xor_test_zero_skip_pkg::ram_wr_s ram_wr_q;
   logic [7:0] acc_q;
   xor_test_zero_skip_pkg::flags_s flags_q;
   logic flags_we_q;
   logic [11:0] indirect_pointer_0_q;
   logic [11:0] indirect_pointer_1_q;
   logic [11:0] indirect_pointer_2_q;
   logic return_q;
   logic [20:0] pc_load_q;
   logic nop_cycle_q;
   logic illegal_q;
   logic [7:0] mem [0:4095];
   int errors = 0;
   int comparisons = 0;

   always #5 clk = ~clk;
   // Operand memory answers in the same cycle, as the core expects
   assign ram_rdata = mem[ram_raddr];

   xor_test_zero_skip_ext_set_decode dut (
      .clk(clk), .rst_b(rst_b), .extension_cfg_bit(extension_cfg_bit),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .bank_pointer_reg(bank_pointer_reg), .ram_rdata(ram_rdata), .stack_top(stack_top),
      .ram_raddr(ram_raddr), .ram_wr_q(ram_wr_q), .acc_q(acc_q), .flags_q(flags_q),
      .flags_we_q(flags_we_q), .indirect_pointer_0_q(indirect_pointer_0_q),
      .indirect_pointer_1_q(indirect_pointer_1_q),
      .indirect_pointer_2_q(indirect_pointer_2_q), .return_q(return_q),
      .pc_load_q(pc_load_q), .nop_cycle_q(nop_cycle_q), .illegal_q(illegal_q)
   );

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Word is held across the taking edge; results are read 1 ns after it,
   // while one-cycle pulses still stand and the operand address is still valid
   task automatic issue(input logic [15:0] w);
      @(negedge clk);
      instr_word = w;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
   endtask

   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #20000;
      errors++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'h00;
      end
      mem[12'hF80] = 8'h1A;
      mem[12'h233] = 8'h5A;
      mem[12'h028] = 8'hFF;
      mem[12'h082] = 8'h01;
      mem[12'h060] = 8'h01;
      mem[12'h533] = 8'h3C;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      check("acc", 32'h00, acc_q);
      check("ptr2", 32'h000, indirect_pointer_2_q);
      issue(16'h0AB5);
      check("acc", 32'hB5, acc_q);
      check("flags", 32'h2, flags_q);
      check("flags_we", 32'h1, flags_we_q);
      issue(16'h0AAF);
      check("acc", 32'h1A, acc_q);
      check("flags", 32'h0, flags_q);
      issue(16'h1880);
      check("raddr", 32'hF80, ram_raddr);
      check("acc", 32'h00, acc_q);
      check("flags", 32'h1, flags_q);
      check("we", 32'h0, ram_wr_q.we);
      issue(16'h1B33);
      check("raddr", 32'h233, ram_raddr);
      check("we", 32'h1, ram_wr_q.we);
      check("waddr", 32'h233, ram_wr_q.addr);
      check("wdata", 32'h5A, ram_wr_q.data);
      check("acc", 32'h00, acc_q);
      issue(16'hE8A3);
      check("ptr2", 32'h023, indirect_pointer_2_q);
      check("illegal", 32'h0, illegal_q);
      issue(16'hE83F);
      check("ptr0", 32'h03F, indirect_pointer_0_q);
      check("return", 32'h0, return_q);
      issue(16'hE941);
      check("ptr1", 32'hFFF, indirect_pointer_1_q);
      issue(16'h1805);
      check("raddr", 32'h028, ram_raddr);
      check("acc", 32'hFF, acc_q);
      issue(16'h665F);
      check("raddr", 32'h082, ram_raddr);
      issue(16'h6660);
      check("raddr", 32'h060, ram_raddr);
      check("flags_we", 32'h0, flags_we_q);
      issue(16'h0000);
      check("nop", 32'h0, nop_cycle_q);
      issue(16'hE8C5);
      check("ptr2", 32'h028, indirect_pointer_2_q);
      check("return", 32'h1, return_q);
      check("pc_load", 32'h12345, pc_load_q);
      issue(16'h0000);
      issue(16'hE9C8);
      check("ptr2", 32'h020, indirect_pointer_2_q);
      check("return", 32'h1, return_q);
      issue(16'h0000);
      // Zero-test skip over a one-word and then five two-word instructions
      // Skipped word: one-word first, then every two-word opener
      for (int k = 0; k < 6; k++) begin
         issue(16'h6740);
         check("raddr", 32'h240, ram_raddr);
         check("flags_we", 32'h0, flags_we_q);
         issue(k == 0 ? 16'h0AFF : k == 1 ? 16'hEF00 : k == 2 ? 16'hC123
            : k == 3 ? 16'hEC00 : k == 4 ? 16'hEE00 : 16'hEB00);
         check("nop", 32'h1, nop_cycle_q);
         issue(16'h0A0F);
         check("nop", (k != 0) ? 32'h1 : 32'h0, nop_cycle_q);
         check("acc", 32'hF0, acc_q);
      end
      issue(16'h0A0F);
      check("acc", 32'hFF, acc_q);
      @(negedge clk);
      instr_valid = 1'b0;
      extension_cfg_bit = 1'b0;
      issue(16'hE803);
      check("illegal", 32'h1, illegal_q);
      check("ptr0", 32'h03F, indirect_pointer_0_q);
      issue(16'h6605);
      check("raddr", 32'h005, ram_raddr);
      // Extension off: the indexed move opener is a plain one-word skip
      issue(16'hEB00);
      check("nop", 32'h1, nop_cycle_q);
      issue(16'h0A0F);
      check("nop", 32'h0, nop_cycle_q);
      check("acc", 32'hF0, acc_q);
      // Reset in mid-run while a skip is pending
      issue(16'h6605);
      @(negedge clk);
      instr_valid = 1'b0;
      rst_b = 1'b0;
      bank_pointer_reg = 8'h05;
      @(negedge clk);
      rst_b = 1'b1;
      check("acc", 32'h00, acc_q);
      check("ptr0", 32'h000, indirect_pointer_0_q);
      issue(16'h1933);
      check("raddr", 32'h533, ram_raddr);
      check("nop", 32'h0, nop_cycle_q);
      check("acc", 32'h3C, acc_q);
      @(negedge clk);
      instr_valid = 1'b0;
      final_report();
   end
endmodule // xor_test_zero_skip_ext_set_decode_bench
